// [sgoc_top.sv]
// Switchgear object control: Wishbone registers, command arbitration and eight object channels.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Objects one to six are controllable; seven and eight only report position.
// - Position is two bits; 00 and 11 are undefined, others open or closed.
// - Each command pulse ends by the programmable maximum pulse length.
// - Missing the new position in time sets object failure and an undefined event.
// - Completion timeout only supervises the ready input, ignored when none selected.
// - Status-only objects fail with an event when a change exceeds their timeout.
// - Separate open and close outputs pulse for input, remote or auto-reclose commands.
// - Interlock blocking suppresses a command so no pulse is issued.
// - Both select-then-execute and direct commands exist for every controllable object.
// - Input-driven commands fire on a rising edge of the chosen signal.
// - Local inputs act only in local state, remote inputs only in remote.
// - Local mode accepts front panel commands and rejects remote serial ones.
// - Remote mode rejects front panel commands and accepts remote serial ones.
// - Local or remote mode comes from the panel bit or a chosen input.
// - Remote commands need no password.
module sgoc_top
    import sgoc_pkg::*;
#(
    parameter int TICK_CYCLES = SGOC_TICK_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    input  wire logic [15:0] sig_i,
    input  wire logic [5:0]  block_i,
    input  wire logic [5:0]  ar_open_i,
    input  wire logic [5:0]  ar_close_i,
    output var  logic [5:0]  open_o,
    output var  logic [5:0]  close_o,
    output var  logic [7:0]  obj_fail_o,
    output var  logic        irq_o
);
    typedef struct packed {
        logic              ack;
        logic [31:0]       rdat;
        logic              remote_bit;
        logic [4:0]        lr_sel;
        sgoc_tmr_t         tmr;
        logic [7:0][20:0]  psel;
        logic [5:0][28:0]  csel;
        logic [5:0]        pend_v;
        logic [5:0]        pend_cls;
        logic [5:0]        cmd_open;
        logic [5:0]        cmd_close;
        logic [15:0]       sig_prev;
        logic [8:0]        irq_stat;
        logic [8:0]        irq_mask;
        logic              irq;
        logic [17:0]       tick_cnt;
        logic              tick;
    } sgoc_top_st_t;

    sgoc_top_st_t s_r;
    sgoc_top_st_t s_nxt;

    logic [7:0][1:0] ch_pos;
    logic [7:0]      ch_open;
    logic [7:0]      ch_close;
    logic [7:0]      ch_fail;
    logic [7:0]      ch_evt;
    logic [7:0]      pos_open;
    logic [7:0]      pos_close;
    logic [7:0]      rdy;
    logic [7:0]      rdy_en;
    logic            remote;

    // Level of the signal picked by a five-bit select code; code zero means none.
    function automatic logic pick(input logic [15:0] v, input logic [4:0] code);
        logic r;
        r = 1'b0;
        if (code != 5'h00) begin
            r = v[code[3:0] - 4'h1];
        end
        return r;
    endfunction

    // Byte-lane merge for register writes.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Mode comes from a chosen input when one is set, else from the panel bit.
    assign remote = (s_r.lr_sel != 5'h00) ? pick(sig_i, s_r.lr_sel) : s_r.remote_bit;

    // Position and ready contacts are steered by the per-object select codes.
    always_comb begin
        for (int i = 0; i < SGOC_NOBJ; i++) begin
            pos_open[i]  = pick(sig_i, s_r.psel[i][4:0]);
            pos_close[i] = pick(sig_i, s_r.psel[i][12:8]);
            rdy[i]       = pick(sig_i, s_r.psel[i][20:16]);
            rdy_en[i]    = (s_r.psel[i][20:16] != 5'h00);
        end
    end

    // Only the first six channels may drive command pulses.
    for (genvar g = 0; g < SGOC_NOBJ; g++) begin : g_chan
        sgoc_obj_chan #(
            .CTL (g < SGOC_NCTL)
        ) u_chan (
            .clk_i       (clk_i),
            .rst_i       (rst_i),
            .tick_i      (s_r.tick),
            .open_pos_i  (pos_open[g]),
            .close_pos_i (pos_close[g]),
            .ready_i     (rdy[g]),
            .ready_en_i  (rdy_en[g]),
            .cmd_open_i  ((g < SGOC_NCTL) ? s_r.cmd_open[g % SGOC_NCTL] : 1'b0),
            .cmd_close_i ((g < SGOC_NCTL) ? s_r.cmd_close[g % SGOC_NCTL] : 1'b0),
            .tmr_i       (s_r.tmr),
            .pos_o       (ch_pos[g]),
            .open_o      (ch_open[g]),
            .close_o     (ch_close[g]),
            .fail_o      (ch_fail[g]),
            .evt_o       (ch_evt[g])
        );
    end

    // Bus decode, command arbitration, interrupts and the tick divider.
    always_comb begin
        logic        acc;
        logic        wr;
        logic        cmd_wr;
        logic [2:0]  cobj;
        logic        ccls;
        logic [1:0]  ckind;
        logic        csrc;
        logic        op_o;
        logic        op_c;
        logic        rej;
        logic [8:0]  set_bits;
        logic [31:0] rd;
        logic [31:0] w;
        acc      = wb_cyc_i && wb_stb_i && !s_r.ack;
        wr       = acc && wb_we_i;
        cmd_wr   = wr && (wb_adr_i == SGOC_CMD_OFS) && wb_sel_i[0];
        cobj     = wb_dat_i[2:0];
        ccls     = wb_dat_i[SGOC_CMD_CLS];
        ckind    = wb_dat_i[SGOC_CMD_KIND +: 2];
        csrc     = wb_dat_i[SGOC_CMD_SRC];
        op_o     = 1'b0;
        op_c     = 1'b0;
        rej      = 1'b0;
        set_bits = '0;
        rd       = 32'h0000_0000;
        w        = 32'h0000_0000;
        s_nxt    = s_r;

        // Classic Wishbone: answer one cycle after the strobe, drop ack next cycle.
        s_nxt.ack = acc;
        s_nxt.sig_prev = sig_i;

        // Ticks are 10 ms enable pulses; all timers count them.
        s_nxt.tick = 1'b0;
        if (s_r.tick_cnt >= 18'(TICK_CYCLES - 1)) begin
            s_nxt.tick_cnt = 18'h00000;
            s_nxt.tick     = 1'b1;
        end else begin
            s_nxt.tick_cnt = s_r.tick_cnt + 18'h00001;
        end

        // Register writes; unmapped addresses are acked and ignored.
        if (wr) begin
            case (wb_adr_i)
                SGOC_CTRL_OFS: begin
                    w = merge({19'h0, s_r.lr_sel, 7'h0, s_r.remote_bit}, wb_dat_i, wb_sel_i);
                    s_nxt.remote_bit = w[0];
                    s_nxt.lr_sel     = w[SGOC_CTRL_LRS +: 5];
                end
                SGOC_IRQM_OFS: begin
                    w = merge({23'h0, s_r.irq_mask}, wb_dat_i, wb_sel_i);
                    s_nxt.irq_mask = w[8:0];
                end
                SGOC_PULSE_OFS: begin
                    w = merge({16'h0, s_r.tmr.pulse_len}, wb_dat_i, wb_sel_i);
                    s_nxt.tmr.pulse_len = w[15:0];
                end
                SGOC_COMPL_OFS: begin
                    w = merge({16'h0, s_r.tmr.compl_to}, wb_dat_i, wb_sel_i);
                    s_nxt.tmr.compl_to = w[15:0];
                end
                SGOC_OBJTO_OFS: begin
                    w = merge({16'h0, s_r.tmr.obj_to}, wb_dat_i, wb_sel_i);
                    s_nxt.tmr.obj_to = w[15:0];
                end
                default: begin
                    for (int i = 0; i < SGOC_NOBJ; i++) begin
                        if (wb_adr_i == SGOC_PSEL_OFS + 8'(4 * i)) begin
                            w = merge({11'h0, s_r.psel[i]}, wb_dat_i, wb_sel_i);
                            s_nxt.psel[i] = w[20:0];
                        end
                    end
                    for (int i = 0; i < SGOC_NCTL; i++) begin
                        if (wb_adr_i == SGOC_CSEL_OFS + 8'(4 * i)) begin
                            w = merge({3'h0, s_r.csel[i]}, wb_dat_i, wb_sel_i);
                            s_nxt.csel[i] = w[28:0];
                        end
                    end
                end
            endcase
        end

        // A command naming a status-only object is refused outright.
        if (cmd_wr && cobj >= 3'(SGOC_NCTL)) begin
            rej = 1'b1;
        end

        // Per-object command collection, one pulse per accepted command.
        for (int g = 0; g < SGOC_NCTL; g++) begin
            op_o = 1'b0;
            op_c = 1'b0;
            // Edge, not level, so a held input cannot re-fire after completion.
            if (remote) begin
                op_o = pick(sig_i, s_r.csel[g][20:16]) && !pick(s_r.sig_prev, s_r.csel[g][20:16]);
                op_c = pick(sig_i, s_r.csel[g][28:24]) && !pick(s_r.sig_prev, s_r.csel[g][28:24]);
            end else begin
                op_o = pick(sig_i, s_r.csel[g][4:0]) && !pick(s_r.sig_prev, s_r.csel[g][4:0]);
                op_c = pick(sig_i, s_r.csel[g][12:8]) && !pick(s_r.sig_prev, s_r.csel[g][12:8]);
            end
            op_o = op_o || ar_open_i[g];
            op_c = op_c || ar_close_i[g];
            // Remote serial commands are taken with no password step.
            if (cmd_wr && cobj == 3'(g)) begin
                if (csrc != remote) begin
                    rej = 1'b1;
                end else begin
                    case (ckind)
                        SGOC_KIND_DIRECT: begin
                            op_o = op_o || !ccls;
                            op_c = op_c || ccls;
                        end
                        SGOC_KIND_SELECT: begin
                            s_nxt.pend_v[g]   = 1'b1;
                            s_nxt.pend_cls[g] = ccls;
                        end
                        SGOC_KIND_EXEC: begin
                            s_nxt.pend_v[g] = 1'b0;
                            if (s_r.pend_v[g] && s_r.pend_cls[g] == ccls) begin
                                op_o = op_o || !ccls;
                                op_c = op_c || ccls;
                            end else begin
                                rej = 1'b1;
                            end
                        end
                        default: begin
                            rej = 1'b1;
                        end
                    endcase
                end
            end
            // Conflicting or interlocked commands never reach the outputs.
            if (op_o && op_c) begin
                rej  = 1'b1;
                op_o = 1'b0;
                op_c = 1'b0;
            end
            if (block_i[g] && (op_o || op_c)) begin
                rej  = 1'b1;
                op_o = 1'b0;
                op_c = 1'b0;
            end
            s_nxt.cmd_open[g]  = op_o;
            s_nxt.cmd_close[g] = op_c;
        end

        // Sticky events; a new event wins over a same-cycle write-one clear.
        set_bits = {rej, ch_evt};
        w = merge(32'h0, wb_dat_i, wb_sel_i);
        if (wr && wb_adr_i == SGOC_IRQS_OFS) begin
            s_nxt.irq_stat = s_r.irq_stat & ~w[8:0];
        end
        s_nxt.irq_stat = s_nxt.irq_stat | set_bits;
        s_nxt.irq      = |(s_nxt.irq_stat & s_nxt.irq_mask);

        // Registered read data; write-only and unmapped words read zero.
        case (wb_adr_i)
            SGOC_CTRL_OFS:   rd = {19'h0, s_r.lr_sel, 7'h0, s_r.remote_bit};
            SGOC_STAT_OFS:   rd = {7'h0, remote, ch_fail, ch_pos};
            SGOC_IRQS_OFS:   rd = {23'h0, s_r.irq_stat};
            SGOC_IRQM_OFS:   rd = {23'h0, s_r.irq_mask};
            SGOC_PULSE_OFS:  rd = {16'h0, s_r.tmr.pulse_len};
            SGOC_COMPL_OFS:  rd = {16'h0, s_r.tmr.compl_to};
            SGOC_OBJTO_OFS:  rd = {16'h0, s_r.tmr.obj_to};
            default: begin
                for (int i = 0; i < SGOC_NOBJ; i++) begin
                    if (wb_adr_i == SGOC_PSEL_OFS + 8'(4 * i)) begin
                        rd = {11'h0, s_r.psel[i]};
                    end
                end
                for (int i = 0; i < SGOC_NCTL; i++) begin
                    if (wb_adr_i == SGOC_CSEL_OFS + 8'(4 * i)) begin
                        rd = {3'h0, s_r.csel[i]};
                    end
                end
            end
        endcase
        s_nxt.rdat = (acc && !wb_we_i) ? rd : 32'h0000_0000;
    end

    // State register with documented reset values for the timers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r               <= '0;
            s_r.tmr.pulse_len <= SGOC_PULSE_RST;
            s_r.tmr.compl_to  <= SGOC_COMPL_RST;
            s_r.tmr.obj_to    <= SGOC_OBJTO_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs are flip-flops here or inside the channels.
    assign wb_dat_o   = s_r.rdat;
    assign wb_ack_o   = s_r.ack;
    assign irq_o      = s_r.irq;
    assign open_o     = ch_open[5:0];
    assign close_o    = ch_close[5:0];
    assign obj_fail_o = ch_fail;
endmodule

`default_nettype wire

// [sgoc_obj_chan.sv]
// Shared constants, carrier types and the per-object position and pulse channel.
`timescale 1ns/100ps
`default_nettype none
package sgoc_pkg;
    // Register byte offsets on the Wishbone bus.
    localparam logic [7:0] SGOC_CTRL_OFS   = 8'h00;
    localparam logic [7:0] SGOC_CMD_OFS    = 8'h04;
    localparam logic [7:0] SGOC_STAT_OFS   = 8'h08;
    localparam logic [7:0] SGOC_IRQS_OFS   = 8'h0c;
    localparam logic [7:0] SGOC_IRQM_OFS   = 8'h10;
    localparam logic [7:0] SGOC_PULSE_OFS  = 8'h14;
    localparam logic [7:0] SGOC_COMPL_OFS  = 8'h18;
    localparam logic [7:0] SGOC_OBJTO_OFS  = 8'h1c;
    localparam logic [7:0] SGOC_PSEL_OFS   = 8'h40;
    localparam logic [7:0] SGOC_CSEL_OFS   = 8'h60;
    // Object counts and field positions.
    localparam int SGOC_NCTL      = 6;
    localparam int SGOC_NOBJ      = 8;
    localparam int SGOC_NSIG      = 16;
    localparam int SGOC_CMD_CLS   = 4;
    localparam int SGOC_CMD_KIND  = 5;
    localparam int SGOC_CMD_SRC   = 7;
    localparam int SGOC_CTRL_LRS  = 8;
    localparam int SGOC_IRQ_REJ   = 8;
    localparam int SGOC_STAT_FAIL = 16;
    localparam int SGOC_STAT_REM  = 24;
    // Position codes; 00 and 11 both mean undefined.
    localparam logic [1:0] SGOC_POS_UNDEF0 = 2'h0;
    localparam logic [1:0] SGOC_POS_OPEN   = 2'h1;
    localparam logic [1:0] SGOC_POS_CLOSED = 2'h2;
    localparam logic [1:0] SGOC_POS_UNDEF1 = 2'h3;
    // Command kinds in the command register.
    localparam logic [1:0] SGOC_KIND_DIRECT = 2'h0;
    localparam logic [1:0] SGOC_KIND_SELECT = 2'h1;
    localparam logic [1:0] SGOC_KIND_EXEC   = 2'h2;
    // Timing: one tick is 10 ms at a 25 MHz clock.
    localparam int SGOC_CLK_HZ   = 25000000;
    localparam int SGOC_TICK_MS  = 10;
    localparam int SGOC_TICK_CYC = SGOC_CLK_HZ / 1000 * SGOC_TICK_MS;
    // Reset values of the three timers, in ticks (1 s each).
    localparam logic [15:0] SGOC_PULSE_RST = 16'h0064;
    localparam logic [15:0] SGOC_COMPL_RST = 16'h0064;
    localparam logic [15:0] SGOC_OBJTO_RST = 16'h0064;

    typedef struct packed {
        logic [15:0] pulse_len;
        logic [15:0] compl_to;
        logic [15:0] obj_to;
    } sgoc_tmr_t;

    typedef struct packed {
        logic [1:0]  pos;
        logic        opn;
        logic        cls;
        logic        busy;
        logic        want_open;
        logic        wait_rdy;
        logic        fail;
        logic        evt;
        logic [15:0] cnt;
    } sgoc_chan_t;
endpackage

// One switchgear object: position decode, pulse timing and failure supervision.
module sgoc_obj_chan
    import sgoc_pkg::*;
#(
    parameter bit CTL = 1'b1
) (
    input  wire logic      clk_i,
    input  wire logic      rst_i,
    input  wire logic      tick_i,
    input  wire logic      open_pos_i,
    input  wire logic      close_pos_i,
    input  wire logic      ready_i,
    input  wire logic      ready_en_i,
    input  wire logic      cmd_open_i,
    input  wire logic      cmd_close_i,
    input  wire sgoc_tmr_t tmr_i,
    output var  logic [1:0] pos_o,
    output var  logic      open_o,
    output var  logic      close_o,
    output var  logic      fail_o,
    output var  logic      evt_o
);
    sgoc_chan_t s_r;
    sgoc_chan_t s_nxt;
    logic [15:0] cnt_inc;
    logic [1:0]  pos_now;
    logic [1:0]  target;

    assign cnt_inc = s_r.cnt + 16'h0001;
    assign pos_now = {close_pos_i, open_pos_i};
    assign target  = s_r.want_open ? SGOC_POS_OPEN : SGOC_POS_CLOSED;

    // Controllable objects run a pulse then optional ready wait; others only watch.
    always_comb begin
        s_nxt     = s_r;
        s_nxt.evt = 1'b0;
        s_nxt.pos = pos_now;
        if (!CTL) begin
            if (pos_now == SGOC_POS_OPEN || pos_now == SGOC_POS_CLOSED) begin
                s_nxt.cnt  = 16'h0000;
                s_nxt.fail = 1'b0;
            end else if (tick_i && !s_r.fail) begin
                if (cnt_inc >= tmr_i.obj_to) begin
                    s_nxt.fail = 1'b1;
                    s_nxt.evt  = 1'b1;
                end else begin
                    s_nxt.cnt = cnt_inc;
                end
            end
        end else if (!s_r.busy) begin
            if (cmd_open_i || cmd_close_i) begin
                s_nxt.busy      = 1'b1;
                s_nxt.want_open = cmd_open_i;
                s_nxt.opn       = cmd_open_i;
                s_nxt.cls       = cmd_close_i;
                s_nxt.cnt       = 16'h0000;
                s_nxt.fail      = 1'b0;
                s_nxt.wait_rdy  = 1'b0;
            end
        end else if (!s_r.wait_rdy) begin
            if (pos_now == target) begin
                s_nxt.opn = 1'b0;
                s_nxt.cls = 1'b0;
                s_nxt.cnt = 16'h0000;
                // Without a ready input the completion timeout is ignored.
                if (ready_en_i && !ready_i) begin
                    s_nxt.wait_rdy = 1'b1;
                end else begin
                    s_nxt.busy = 1'b0;
                end
            end else if (tick_i) begin
                if (cnt_inc >= tmr_i.pulse_len) begin
                    s_nxt.opn  = 1'b0;
                    s_nxt.cls  = 1'b0;
                    s_nxt.busy = 1'b0;
                    s_nxt.fail = 1'b1;
                    s_nxt.evt  = 1'b1;
                end else begin
                    s_nxt.cnt = cnt_inc;
                end
            end
        end else if (ready_i) begin
            s_nxt.busy     = 1'b0;
            s_nxt.wait_rdy = 1'b0;
        end else if (tick_i) begin
            if (cnt_inc >= tmr_i.compl_to) begin
                s_nxt.busy     = 1'b0;
                s_nxt.wait_rdy = 1'b0;
                s_nxt.fail     = 1'b1;
                s_nxt.evt      = 1'b1;
            end else begin
                s_nxt.cnt = cnt_inc;
            end
        end
    end

    // State register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pos_o   = s_r.pos;
    assign open_o  = s_r.opn;
    assign close_o = s_r.cls;
    assign fail_o  = s_r.fail;
    assign evt_o   = s_r.evt;
endmodule

`default_nettype wire

// [sgoc_props.sv]
// Port checker for the switchgear object control block.
`timescale 1ns/100ps
`default_nettype none
module sgoc_props import sgoc_pkg::*; #(
    parameter int TICK_CYCLES = 10
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [15:0] sig_i,
    input wire logic [5:0]  block_i,
    input wire logic [5:0]  ar_open_i,
    input wire logic [5:0]  ar_close_i,
    input wire logic [5:0]  open_o,
    input wire logic [5:0]  close_o,
    input wire logic [7:0]  obj_fail_o,
    input wire logic        irq_o
);
    int hi_cnt;
    // Length of the running pulse on the first object; the timer is left at its reset value.
    always_ff @(posedge clk_i) hi_cnt <= (rst_i || !(open_o[0] || close_o[0])) ? 0 : hi_cnt + 1;
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("late ack");
    chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
    chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("stray read data");
    chk_reset_quiet: assert property ($fell(rst_i) |-> !wb_ack_o && !irq_o && {open_o, close_o, obj_fail_o} == 20'h0)
        else $error("outputs active after reset");
    chk_pulse_max: assert property (hi_cnt <= int'(SGOC_PULSE_RST) * TICK_CYCLES + 4) else $error("pulse too long");
    chk_pos_end: assert property (open_o[0] && sig_i[1:0] == 2'h1 |-> ##[1:3] !open_o[0]) else $error("pulse kept");
    chk_block_stop: assert property ((open_o & ~$past(open_o) & $past(block_i, 2)) == 6'h0) else $error("blocked");
    chk_fail_cause: assert property ($rose(obj_fail_o[0]) |-> $past(open_o[0] || close_o[0]))
        else $error("failure without a pulse");
    cov_open: cover property ($rose(open_o[0]));
    cov_fail: cover property ($rose(obj_fail_o[0]));
    cov_irq: cover property ($rose(irq_o));
endmodule
`default_nettype wire

// [sgoc_gear_model.sv]
// Contact model of six switchgear objects that travel after a command.
`timescale 1ns/100ps
`default_nettype none
module sgoc_gear_model import sgoc_pkg::*; #(
    parameter int TRAVEL = 5
) (
    input  wire logic        clk_i,
    input  wire logic        stuck_i,
    input  wire logic [5:0]  open_i,
    input  wire logic [5:0]  close_i,
    output var  logic [11:0] pos_o
);
    int cnt [6];
    initial pos_o = 12'h000;
    // Both contacts read low while moving, so a pulse cannot end before the travel is over.
    always @(posedge clk_i) begin
        for (int n = 0; n < 6; n++) begin
            if (stuck_i || !(open_i[n] ^ close_i[n])) begin
                cnt[n] <= 0;
            end else if (cnt[n] < TRAVEL) begin
                cnt[n] <= cnt[n] + 1;
                pos_o[2*n+:2] <= 2'h0;
            end else begin
                pos_o[2*n+:2] <= {close_i[n], open_i[n]};
            end
        end
    end
endmodule
`default_nettype wire

// [sgoc_top_test.sv]
// Self-checking bench for switchgear object control.
`timescale 1ns/100ps
`default_nettype none
module sgoc_top_test import sgoc_pkg::*;;
    typedef struct {logic [7:0] c; logic [11:0] s; logic rej;} sgoc_row_t;
    // Panel and serial commands with the pulses and reject flag that they should give.
    sgoc_row_t rows [8] = '{'{8'h00, 12'h001, 1'b0}, '{8'h11, 12'h080, 1'b0}, '{8'h90, 12'h000, 1'b1},
        '{8'h06, 12'h000, 1'b1}, '{8'h42, 12'h000, 1'b1}, '{8'h22, 12'h000, 1'b0}, '{8'h42, 12'h004, 1'b0},
        '{8'h62, 12'h000, 1'b1}};
    logic        clk_i, rst_i, req, wb_we, wb_ack, stuck, irq;
    logic [7:0]  wb_adr, obj_fail;
    logic [31:0] wb_dat, wb_rd, q;
    logic [5:0]  block, ar_close, open_o, close_o;
    logic [3:0]  bsig;
    logic [11:0] gear_pos;
    int          bad_count, checked, n;
    sgoc_top #(.TICK_CYCLES(10)) i_sgoc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack),
        .sig_i({bsig, gear_pos}), .block_i(block), .ar_open_i(6'h00), .ar_close_i(ar_close), .open_o(open_o),
        .close_o(close_o), .obj_fail_o(obj_fail), .irq_o(irq));
    sgoc_gear_model i_sgoc_gear_model (.clk_i(clk_i), .stuck_i(stuck), .open_i(open_o), .close_i(close_o),
        .pos_o(gear_pos));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // One classic cycle held until ack is sampled; a lost ack ends the run.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int k;
        @(posedge clk_i);
        {req, wb_we, wb_adr, wb_dat} <= {1'b1, w, a, d};
        for (k = 0; k < 20 && wb_ack !== 1'b1; k++) @(posedge clk_i);
        r = wb_rd;
        req <= 1'b0;
        chk("ack", 32'h1, {31'h0, wb_ack});
        if (wb_ack !== 1'b1) close_out();
    endtask
    // Gathers every pulse over a window longer than a normal travel.
    task automatic watch(input string nm, input logic [11:0] e);
        logic [11:0] seen;
        seen = 12'h000;
        repeat (40) begin
            @(posedge clk_i);
            seen |= {close_o, open_o};
        end
        chk(nm, {20'h0, e}, {20'h0, seen});
    endtask
    task automatic cmd(input logic [7:0] c, input string nm, input logic [11:0] e);
        bus(1'b1, SGOC_CMD_OFS, {24'h0, c}, q);
        watch(nm, e);
    endtask
    task automatic mode(input logic e);
        bus(1'b0, SGOC_STAT_OFS, 32'h0, q);
        chk("remote mode", {31'h0, e}, {31'h0, q[24]});
    endtask
    initial begin
        {rst_i, req, wb_we, stuck, bsig, block, ar_close, wb_adr, wb_dat} = {1'b1, 59'h0};
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 6; k++) bus(1'b1, SGOC_PSEL_OFS + 8'(4 * k),
            32'((k == 1) << 20 | (2 * k + 2) << 8 | (2 * k + 1)), q);
        foreach (rows[r]) begin
            cmd(rows[r].c, "row pulses", rows[r].s);
            bus(1'b0, SGOC_IRQS_OFS, 32'h0, q);
            chk("row reject", {31'h0, rows[r].rej}, {31'h0, q[8]});
            bus(1'b1, SGOC_IRQS_OFS, 32'h100, q);
        end
        bus(1'b0, SGOC_STAT_OFS, 32'h0, q);
        chk("positions", 32'h19, {26'h0, q[5:0]});
        bus(1'b0, 8'hfc, 32'h0, q);
        chk("unmapped", 32'h0, q);
        block <= 6'h10;
        cmd(8'h04, "blocked", 12'h000);
        {block, ar_close} <= {6'h00, 6'h04};
        @(posedge clk_i);
        ar_close <= 6'h00;
        watch("reclose", 12'h100);
        bus(1'b1, SGOC_CTRL_OFS, 32'h1, q);
        mode(1'b1);
        cmd(8'h03, "panel in remote", 12'h000);
        cmd(8'h83, "serial in remote", 12'h008);
        bus(1'b1, SGOC_CSEL_OFS + 8'h14, 32'h000d000e, q);
        bsig <= 4'h2;
        watch("local input", 12'h000);
        bsig <= 4'h3;
        watch("remote input", 12'h020);
        watch("held input", 12'h000);
        bus(1'b1, SGOC_CTRL_OFS, 32'h0f00, q);
        mode(1'b0);
        bsig <= 4'h4;
        bus(1'b1, SGOC_IRQM_OFS, 32'h1, q);
        mode(1'b1);
        bus(1'b1, SGOC_CTRL_OFS, 32'h0, q);
        stuck <= 1'b1;
        cmd(8'h10, "stuck pulse", 12'h040);
        for (n = 0; n < 1500 && obj_fail[0] !== 1'b1; n++) @(posedge clk_i);
        chk("fail delay", 32'h1, 32'(n > 900 && n < 1500));
        repeat (2) @(posedge clk_i);
        chk("irq raised", 32'h1, {31'h0, irq});
        bus(1'b1, SGOC_IRQM_OFS, 32'h0, q);
        bus(1'b0, SGOC_IRQS_OFS, 32'h0, q);
        chk("masked irq", 32'h2, {30'h0, q[0], irq});
        bus(1'b1, SGOC_IRQS_OFS, 32'h1, q);
        bus(1'b1, SGOC_IRQM_OFS, 32'h1, q);
        bus(1'b0, SGOC_IRQS_OFS, 32'h0, q);
        chk("cleared irq", 32'h0, {30'h0, q[0], irq});
        chk("late fails", 32'h7, {29'h0, obj_fail[7:6], obj_fail[1]});
        close_out();
    end
endmodule
bind sgoc_top sgoc_props #(.TICK_CYCLES(TICK_CYCLES)) i_sgoc_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sig_i(sig_i), .block_i(block_i), .ar_open_i(ar_open_i),
    .ar_close_i(ar_close_i), .open_o(open_o), .close_o(close_o), .obj_fail_o(obj_fail_o), .irq_o(irq_o));
`default_nettype wire
